// File: rtl/csd_decoder.sv
// eight-bank chip-select decoder with its register file
//
// Contract
// - writes to unassigned offsets or reserved bits change nothing.
// - external masters may read and write every chip-select register.
// - each bank compares its 16-bit base with address bits 31..16.
// - a set ignore bit makes that address bit a don't-care.
// - a bank spans 2**(16+set ignore bits) bytes, possibly in pieces.
// - with write protect set, writes do not select the bank.
// - alternate master clear drops s/u code/data masks on alternate-master access.
// - each access-space mask bit set excludes its access type.
// - a masked access gets no select and runs a plain bus cycle.
// - no select asserts while its valid bit is clear, save boot bank 0.
// - reset clears every valid bit.
// - until bank 0 is valid, bank 0 selects every external access alone.
// - reserved locations read as zero.
`timescale 1ns/1ns
`default_nettype none
`include "csd_defs.svh"
module csd_decoder
	import csd_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        reg_sel_i,
	input  wire logic        reg_wr_i,
	input  wire logic [11:0] reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_ext_i,
	output logic      [31:0] reg_rdata_o,
	input  wire logic        acc_req_i,
	input  wire logic [31:0] acc_addr_i,
	input  wire logic [2:0]  acc_space_i,
	input  wire logic        acc_write_i,
	input  wire logic        acc_alt_i,
	output logic      [7:0]  cs_n_o,
	output logic             ext_cycle_o
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		csd_bank_t [7:0] bank;
		logic [31:0]     rdata;
		logic [7:0]      cs_n;
		logic            ext;
	} csd_state_t;

	csd_state_t st_r;
	csd_state_t st_nxt;
	logic [7:0] hit;

	// ************************************************************
	// decode helpers
	// ************************************************************
	function automatic logic in_space(input logic [11:0] a);
		in_space = a >= `CSD_SPACE_LO && a <= `CSD_SPACE_HI &&
		           a[1:0] == 2'b00;
	endfunction : in_space

	function automatic logic [2:0] bank_of(input logic [11:0] a);
		logic [11:0] rel;
		rel = a - `CSD_SPACE_LO;
		bank_of = 3'(rel / `CSD_BANK_STRIDE);
	endfunction : bank_of

	function automatic logic [3:0] slot_of(input logic [11:0] a);
		logic [11:0] rel;
		rel = a - `CSD_SPACE_LO;
		slot_of = 4'(rel % `CSD_BANK_STRIDE);
	endfunction : slot_of

	// ************************************************************
	// per-bank match
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < `CSD_NBANK; g++) begin : g_bank
			csd_bank_match u_match (
				.base_i    (st_r.bank[g].base),
				.mask_i    (st_r.bank[g].mask),
				.addr_hi_i (acc_addr_i[31:16]),
				.space_i   (acc_space_i),
				.write_i   (acc_write_i),
				.alt_i     (acc_alt_i),
				.hit_o     (hit[g])
			);
		end
	endgenerate

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic [2:0] b;
		logic [3:0] s;
		logic       ok;
		b = bank_of(reg_addr_i);
		s = slot_of(reg_addr_i);
		ok = in_space(reg_addr_i);
		st_nxt = st_r;
		st_nxt.rdata = 32'h00000000;
		// external masters see the same map as the core
		if (reg_sel_i && ok && (reg_ext_i || !reg_ext_i)) begin
			if (reg_wr_i) begin
				case (s)
					`CSD_OFS_BASE: st_nxt.bank[b].base = reg_wdata_i[31:16];
					`CSD_OFS_MASK: st_nxt.bank[b].mask =
						reg_wdata_i & `CSD_MASK_WMASK;
					`CSD_OFS_CTRL: st_nxt.bank[b].ctrl =
						reg_wdata_i[15:0] & `CSD_CTRL_WMASK;
					default: ;
				endcase
			end else begin
				case (s)
					`CSD_OFS_BASE: st_nxt.rdata = {st_r.bank[b].base, 16'h0000};
					`CSD_OFS_MASK: st_nxt.rdata = st_r.bank[b].mask;
					`CSD_OFS_CTRL: st_nxt.rdata = {16'h0000, st_r.bank[b].ctrl};
					default:       st_nxt.rdata = 32'h00000000;
				endcase
			end
		end
		st_nxt.cs_n = 8'hFF;
		st_nxt.ext = 1'b0;
		if (acc_req_i) begin
			if (!st_r.bank[0].mask[`CSD_V_BIT]) begin
				st_nxt.cs_n = 8'hFE;
			end else begin
				st_nxt.cs_n = ~hit;
				st_nxt.ext = hit == 8'h00;
			end
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < `CSD_NBANK; i++) begin
				st_r.bank[i].base <= `CSD_BASE_RST;
				st_r.bank[i].mask <= `CSD_MASK_RST;
				st_r.bank[i].ctrl <= `CSD_CTRL_RST;
			end
			st_r.rdata <= 32'h00000000;
			st_r.cs_n  <= 8'hFF;
			st_r.ext   <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o = st_r.rdata;
	assign cs_n_o      = st_r.cs_n;
	assign ext_cycle_o = st_r.ext;
endmodule : csd_decoder
`default_nettype wire

// File: rtl/csd_defs.svh
// offsets, field positions and reset values of the chip-select decoder
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH
`define CSD_NBANK        8
`define CSD_SPACE_LO     12'h080
`define CSD_SPACE_HI     12'h0DC
`define CSD_BANK_STRIDE  12'h00C
`define CSD_OFS_BASE     4'h0
`define CSD_OFS_MASK     4'h4
`define CSD_OFS_CTRL     4'h8
`define CSD_MASK_HI      31
`define CSD_MASK_LO      16
`define CSD_WP_BIT       8
`define CSD_AM_BIT       6
`define CSD_CI_BIT       5
`define CSD_SC_BIT       4
`define CSD_SD_BIT       3
`define CSD_UC_BIT       2
`define CSD_UD_BIT       1
`define CSD_V_BIT        0
`define CSD_MASK_WMASK   32'hFFFF017F
`define CSD_CTRL_WMASK   16'h3DF8
`define CSD_BASE_RST     16'h0000
`define CSD_MASK_RST     32'h00000000
`define CSD_CTRL_RST     16'h0000
`endif

// File: rtl/csd_pkg.sv
// types shared by the chip-select decoder files
`default_nettype none
package csd_pkg;
	typedef enum logic [2:0] {
		CSD_SP_CPU,
		CSD_SP_SCODE,
		CSD_SP_SDATA,
		CSD_SP_UCODE,
		CSD_SP_UDATA
	} csd_space_t;
	typedef struct packed {
		logic [15:0] base;
		logic [31:0] mask;
		logic [15:0] ctrl;
	} csd_bank_t;
endpackage : csd_pkg
`default_nettype wire

// File: rtl/csd_bank_match.sv
// single-bank address and access-type match
`timescale 1ns/1ns
`default_nettype none
`include "csd_defs.svh"
module csd_bank_match
	import csd_pkg::*;
(
	input  wire logic [15:0] base_i,
	input  wire logic [31:0] mask_i,
	input  wire logic [15:0] addr_hi_i,
	input  wire logic [2:0]  space_i,
	input  wire logic        write_i,
	input  wire logic        alt_i,
	output logic             hit_o
);
	logic [15:0] ignore;
	logic        addr_ok;
	logic        space_masked;
	logic        wp_block;
	logic        typed;

	assign ignore  = mask_i[`CSD_MASK_HI:`CSD_MASK_LO];
	// set ignore bits widen the block to 2**(16+popcount), holes allowed
	assign addr_ok = ((addr_hi_i ^ base_i) & ~ignore) == 16'h0000;

	always_comb begin
		case (csd_space_t'(space_i))
			CSD_SP_CPU:   space_masked = mask_i[`CSD_CI_BIT];
			CSD_SP_SCODE: space_masked = mask_i[`CSD_SC_BIT];
			CSD_SP_SDATA: space_masked = mask_i[`CSD_SD_BIT];
			CSD_SP_UCODE: space_masked = mask_i[`CSD_UC_BIT];
			CSD_SP_UDATA: space_masked = mask_i[`CSD_UD_BIT];
			default:      space_masked = 1'b0;
		endcase
	end

	// alternate master ignores s/u code/data masks unless enabled
	assign typed = alt_i && !mask_i[`CSD_AM_BIT] &&
	               (space_i != 3'(CSD_SP_CPU));
	assign wp_block = write_i && mask_i[`CSD_WP_BIT];
	assign hit_o = mask_i[`CSD_V_BIT] && addr_ok && !wp_block &&
	               (typed || !space_masked);
endmodule : csd_bank_match
`default_nettype wire

// File: testbench/csd_decoder_properties.sv
// port assertions for the chip-select decoder
`timescale 1ns/1ns
`default_nettype none
module csd_decoder_chk (
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire logic        reg_sel_i,
	input wire logic        reg_wr_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        acc_req_i,
	input wire logic [7:0]  cs_n_o,
	input wire logic        ext_cycle_o
);
	logic v0_r;
	// bank 0 valid bit as seen on the register bus
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i)
			v0_r <= 1'b0;
		else if (reg_sel_i && reg_wr_i && reg_addr_i == 12'h084)
			v0_r <= reg_wdata_i[0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_boot;
		acc_req_i && !v0_r;
	endsequence
	idle_cs_a: assert property (!acc_req_i |=> cs_n_o == 8'hFF)
		else $error("select without request");
	idle_ext_a: assert property (!acc_req_i |=> !ext_cycle_o)
		else $error("plain cycle without request");
	rd_idle_a: assert property (!reg_sel_i || reg_wr_i |=> reg_rdata_o == 0)
		else $error("read data without read");
	ext_no_cs_a: assert property (ext_cycle_o |-> cs_n_o == 8'hFF)
		else $error("plain cycle with select");
	boot_sel_a: assert property (s_boot |=> cs_n_o == 8'hFE)
		else $error("boot select missing");
	boot_noext_a: assert property (s_boot |=> !ext_cycle_o)
		else $error("plain cycle in boot");
	boot_alone_a: assert property (!v0_r |=> cs_n_o[7:1] == 7'h7F)
		else $error("other bank in boot");
	ext_valid_a: assert property (ext_cycle_o |-> $past(v0_r))
		else $error("plain cycle before valid");
endmodule : csd_decoder_chk
bind csd_decoder csd_decoder_chk i_csd_decoder_chk (
	.clk_i       (clk_i),
	.arst_n_i    (arst_n_i),
	.reg_sel_i   (reg_sel_i),
	.reg_wr_i    (reg_wr_i),
	.reg_addr_i  (reg_addr_i),
	.reg_wdata_i (reg_wdata_i),
	.reg_rdata_o (reg_rdata_o),
	.acc_req_i   (acc_req_i),
	.cs_n_o      (cs_n_o),
	.ext_cycle_o (ext_cycle_o)
);
`default_nettype wire

// File: testbench/csd_mem_model.sv
// far-side memory model latching the last selected banks
`timescale 1ns/1ns
`default_nettype none
module csd_mem_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] cs_n_i,
	output logic      [7:0] sel_o
);
	initial sel_o = 8'h00;
	always @(posedge clk_i)
		if (!(&cs_n_i))
			sel_o <= ~cs_n_i;
endmodule : csd_mem_model
`default_nettype wire

// File: testbench/test_csd_decoder.sv
// self-checking bench for the chip-select decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %h got %h", n, e, s); end end
module test_csd_decoder;
	logic        clk_i = 0, arst_n_i = 0, reg_sel_i = 0, reg_wr_i = 0;
	logic        reg_ext_i = 0, acc_req_i = 0, acc_write_i = 0;
	logic        acc_alt_i = 0, ext_cycle_o;
	logic [11:0] reg_addr_i = 0;
	logic [31:0] reg_wdata_i = 0, reg_rdata_o, acc_addr_i = 0;
	logic [2:0]  acc_space_i = 0;
	logic [7:0]  cs_n_o, sel;
	int          bad_count = 0, checked = 0;
	always #4 clk_i = ~clk_i;
	csd_decoder i_csd_decoder (
		.clk_i       (clk_i),
		.arst_n_i    (arst_n_i),
		.reg_sel_i   (reg_sel_i),
		.reg_wr_i    (reg_wr_i),
		.reg_addr_i  (reg_addr_i),
		.reg_wdata_i (reg_wdata_i),
		.reg_ext_i   (reg_ext_i),
		.reg_rdata_o (reg_rdata_o),
		.acc_req_i   (acc_req_i),
		.acc_addr_i  (acc_addr_i),
		.acc_space_i (acc_space_i),
		.acc_write_i (acc_write_i),
		.acc_alt_i   (acc_alt_i),
		.cs_n_o      (cs_n_o),
		.ext_cycle_o (ext_cycle_o)
	);
	csd_mem_model i_csd_mem_model (.clk_i(clk_i), .cs_n_i(cs_n_o), .sel_o(sel));
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_sel_i <= 1;
		reg_wr_i <= 1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_sel_i <= 0;
	endtask : wr
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_sel_i <= 1;
		reg_wr_i <= 0;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_sel_i <= 0;
		#1 `CHK("rdata", e, reg_rdata_o)
	endtask : rc
	task automatic ac(input logic [31:0] a, input logic [2:0] s,
		input logic w, l, input logic [7:0] cs, input logic ex);
		@(posedge clk_i);
		acc_req_i <= 1;
		acc_addr_i <= a;
		acc_space_i <= s;
		acc_write_i <= w;
		acc_alt_i <= l;
		@(posedge clk_i);
		acc_req_i <= 0;
		#1 `CHK("cs_n", cs, cs_n_o)
		`CHK("ext", ex, ext_cycle_o)
	endtask : ac
	task automatic t_boot();
		rc(12'h084, 32'h0);
		wr(12'h090, 32'h00FF_0001);
		wr(12'h08C, 32'h0200_0000);
		ac(32'h0200_0000, 3'd4, 1, 0, 8'hFE, 0);
		ac(32'hFFFF_0000, 3'd0, 1, 1, 8'hFE, 0);
	endtask : t_boot
	task automatic t_decode();
		wr(12'h084, 32'h0008_0001);
		`CHK("mem", 8'h01, sel)
		ac(32'h0008_1234, 3'd2, 0, 0, 8'hFE, 0);
		ac(32'h0000_FFFF, 3'd2, 0, 0, 8'hFE, 0);
		ac(32'h0004_0000, 3'd2, 0, 0, 8'hFF, 1);
		ac(32'h02FF_0000, 3'd4, 0, 0, 8'hFD, 0);
		ac(32'h0300_0000, 3'd4, 0, 0, 8'hFF, 1);
	endtask : t_decode
	task automatic t_prot();
		wr(12'h090, 32'h00FF_0101);
		ac(32'h0280_0000, 3'd4, 1, 0, 8'hFF, 1);
		ac(32'h0280_0000, 3'd4, 0, 0, 8'hFD, 0);
	endtask : t_prot
	task automatic t_space();
		for (int s = 0; s < 5; s++) begin
			wr(12'h090, 32'h00FF_0001 | (32'h20 >> s));
			ac(32'h0200_0000, 3'(s), 0, 0, 8'hFF, 1);
			ac(32'h0200_0000, 3'((s + 1) % 5), 0, 0, 8'hFD, 0);
			ac(32'h0200_0000, 3'(s), 0, 1, s ? 8'hFD : 8'hFF, s == 0);
		end
		wr(12'h090, 32'h00FF_0051);
		ac(32'h0200_0000, 3'd1, 0, 1, 8'hFF, 1);
	endtask : t_space
	task automatic t_resv();
		reg_ext_i <= 1;
		wr(12'h08C, 32'hFFFF_FFFF);
		rc(12'h08C, 32'hFFFF_0000);
		wr(12'h090, 32'hFFFF_FFFF);
		wr(12'h0E0, 32'hFFFF_FFFF);
		wr(12'h091, 32'h0);
		rc(12'h090, 32'hFFFF_017F);
		rc(12'h080, 32'h0);
		rc(12'h0E0, 32'h0);
		wr(12'h094, 32'hFFFF_FFFF);
		rc(12'h094, 32'h0000_3DF8);
		wr(12'h090, 32'h00FF_0000);
		ac(32'h0200_0000, 3'd4, 0, 0, 8'hFF, 1);
	endtask : t_resv
	task automatic t_reset();
		@(posedge clk_i);
		arst_n_i <= 0;
		repeat (3) @(posedge clk_i);
		arst_n_i <= 1;
		rc(12'h084, 32'h0);
		rc(12'h08C, 32'h0);
		ac(32'h0008_0000, 3'd2, 0, 0, 8'hFE, 0);
	endtask : t_reset
	task automatic give_verdict();
		$display("mismatches %0d of %0d checks", bad_count, checked);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (10) @(posedge clk_i);
		arst_n_i <= 1;
		t_boot();
		t_decode();
		t_prot();
		t_space();
		t_resv();
		t_reset();
		give_verdict();
	end
endmodule : test_csd_decoder
`default_nettype wire
